// ==== lpm_pkg.sv ====
// Constants, encodings and register map of the low-power mode controller
package lpm_pkg;

   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [31:0] ADDR_CLOCK_SEL = 32'h0000_0000;
   localparam logic [31:0] ADDR_WAKE_EN = 32'h0000_0004;
   localparam logic [31:0] ADDR_KEY_CFG = 32'h0000_0008;
   localparam logic [31:0] ADDR_PERIPH_EN = 32'h0000_000c;
   localparam logic [31:0] ADDR_MODE_STAT = 32'h0000_0010;
   localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0014;
   localparam logic [31:0] ADDR_IRQ_CLR = 32'h0000_0018;
   localparam logic [31:0] ADDR_IRQ_EN = 32'h0000_001c;
   localparam logic [31:0] ADDR_RET_ADDR = 32'h0000_0020;

   // -----------------------------------------------------------------
   // Widths and field positions
   // -----------------------------------------------------------------
   localparam int KEY_W = 8;
   localparam int PERIPH_W = 8;
   localparam int PC_W = 16;
   localparam int WAKE_EN_W = 5;
   localparam int EV_W = 3;
   localparam int OSC_CNT_W = 21;
   localparam int PSTOP_BIT = 0;
   localparam int WAKE_IRQ_BIT = 0;
   localparam int WAKE_CAN_BIT = 1;
   localparam int WAKE_TIMER_BIT = 2;
   localparam int WAKE_WDOG_BIT = 3;
   localparam int WAKE_PERIPH_BIT = 4;
   localparam int KEY_EN_LSB = 0;
   localparam int KEY_EDGE_LSB = 8;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_SRC_LSB = 8;
   localparam int EV_WAKE = 0;
   localparam int EV_STOP_REFUSED = 1;
   localparam int EV_OSC_READY = 2;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic PSTOP_RST = 1'b0;
   localparam logic [WAKE_EN_W-1:0] WAKE_EN_RST = 5'h00;
   localparam logic [KEY_W-1:0] KEY_EN_RST = 8'h00;
   localparam logic [KEY_W-1:0] KEY_EDGE_RST = 8'h00;
   localparam logic [PERIPH_W-1:0] PERIPH_EN_RST = 8'hff;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;
   localparam logic [PC_W-1:0] PC_RST = 16'h0000;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam real CLK_PERIOD_NS = 5.0;
   localparam real OSC_RESTART_MS = 8.00;
   localparam int OSC_RESTART_CYC_DEF =
      int'($ceil(OSC_RESTART_MS * 1.0e6 / CLK_PERIOD_NS));

   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_RUN = 2'h0,
      MODE_WAIT = 2'h1,
      MODE_PSTOP = 2'h3,
      MODE_STOP = 2'h2
   } mode_e;

   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_STACK = 3'h1,
      ST_GATED = 3'h3,
      ST_OSC_WAIT = 3'h2,
      ST_RESTORE = 3'h6
   } seq_e;

   typedef enum logic [2:0] {
      SRC_NONE = 3'h0,
      SRC_NONMASKABLE_INTERRUPT_PIN = 3'h1,
      SRC_IRQ = 3'h2,
      SRC_KEY = 3'h3,
      SRC_CAN = 3'h4,
      SRC_TIMER = 3'h5,
      SRC_WDOG = 3'h6,
      SRC_PERIPH = 3'h7
   } src_e;

endpackage

// ==== lpm_ctrl.sv ====
// Low-power mode controller with AHB-Lite register slave
// What this block does
// R1: Stop ignored while stop-disable bit set
// R2: Pseudo-stop select picks pseudo-stop or stop
// R3: Only stop or wait instruction enters
// R4: Registers stacked before clocks are gated
// R5: Return address is the following instruction
// R6: Stop: oscillator off, external wake only
// R7: Stop: only CAN activity among peripherals
// R8: Interrupt pin falling edge wakes, maskable
// R9: Key wake-up edge selectable, maskable
// R10: Pseudo-stop clocks only timer and watchdog
// R11: Wait halts CPU, enabled peripherals clocked
// R12: Wait: any unmasked interrupt wakes
// R13: Configuration kept in all low-power modes
// R14: Software sets wake-up conditions beforehand
// R15: Wait/pseudo-stop exit fetches vector promptly
// R16: Masked nonmaskable wake resumes next instruction
// R17: Stop exit waits oscillator restart delay
// R18: Clocks restored before service routine starts
module lpm_ctrl
   import lpm_pkg::*;
#(
   parameter int unsigned OSC_RESTART_CYC = OSC_RESTART_CYC_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic stop_instr,
   input wire logic wait_instr,
   input wire logic stop_disable,
   input wire logic nonmaskable_interrupt_pin_mask,
   input wire logic [PC_W-1:0] next_pc,
   input wire logic stack_done,
   output logic stack_req,
   output logic cpu_halt,
   output logic [PC_W-1:0] return_addr,
   output logic vector_fetch,
   output logic resume_next,
   output logic [2:0] wake_source,
   input wire logic irq_n,
   input wire logic nonmaskable_interrupt_pin_n,
   input wire logic [KEY_W-1:0] key_pins,
   input wire logic can_activity,
   input wire logic timer_irq,
   input wire logic wdog_irq,
   input wire logic periph_irq,
   output logic osc_en,
   output logic cpu_clk_en,
   output logic bus_clk_en,
   output logic timer_clk_en,
   output logic can_clk_en,
   output logic [PERIPH_W-1:0] periph_clk_en,
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      seq_e state;
      mode_e mode;
      src_e src;
      logic pstop_sel;
      logic [WAKE_EN_W-1:0] wake_en;
      logic [KEY_W-1:0] key_en;
      logic [KEY_W-1:0] key_edge;
      logic [PERIPH_W-1:0] periph_en;
      logic [EV_W-1:0] ev_stat;
      logic [EV_W-1:0] ev_en;
      logic [PC_W-1:0] ret_addr;
      logic [OSC_CNT_W-1:0] osc_cnt;
      logic irq_prev;
      logic nonmaskable_interrupt_pin_prev;
      logic [KEY_W-1:0] key_prev;
      logic nonmaskable_interrupt_pin_masked;
      logic vector_fetch;
      logic resume_next;
      logic wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
   } ctl_s;

   localparam ctl_s CTL_RST = '{
      state: ST_RUN, mode: MODE_RUN, src: SRC_NONE,
      pstop_sel: PSTOP_RST, wake_en: WAKE_EN_RST,
      key_en: KEY_EN_RST, key_edge: KEY_EDGE_RST,
      periph_en: PERIPH_EN_RST, ev_stat: EV_RST, ev_en: EV_RST,
      ret_addr: PC_RST, osc_cnt: '0, irq_prev: 1'b1, nonmaskable_interrupt_pin_prev: 1'b1,
      key_prev: '0, nonmaskable_interrupt_pin_masked: 1'b0, vector_fetch: 1'b0,
      resume_next: 1'b0, wr_pend: 1'b0, wr_addr: '0, rdata: '0
   };

   localparam logic [OSC_CNT_W-1:0] OSC_LOAD =
      OSC_CNT_W'(OSC_RESTART_CYC - 1);

   ctl_s r;
   ctl_s n;
   logic [KEY_W-1:0] key_hit;
   logic irq_fall;
   logic nonmaskable_interrupt_pin_fall;
   logic gated;
   logic wake_any;
   src_e wake_src;
   logic [EV_W-1:0] ev_set;
   logic stop_take;
   logic wait_take;

   // ----------------------------------------------------------------
   // Wake-up detection
   // ----------------------------------------------------------------
   // Key wake-up per pin, 1 in key_edge selects rising
   for (genvar i = 0; i < KEY_W; i++) begin : g_key
      // R9: edge select per pin
      assign key_hit[i] = r.key_en[i] &
         (r.key_edge[i] ? (key_pins[i] & ~r.key_prev[i])
                        : (~key_pins[i] & r.key_prev[i]));
   end

   assign irq_fall = r.irq_prev & ~irq_n;
   assign nonmaskable_interrupt_pin_fall = r.nonmaskable_interrupt_pin_prev & ~nonmaskable_interrupt_pin_n;
   assign gated = (r.state == ST_GATED);
   assign stop_take = (r.state == ST_RUN) & stop_instr & ~stop_disable;
   assign wait_take = (r.state == ST_RUN) & ~stop_instr & wait_instr;

   // Fixed priority; timer and watchdog are dead with the oscillator off
   always_comb begin
      wake_src = SRC_NONE;
      // R6: only external sources while oscillator off
      if (nonmaskable_interrupt_pin_fall) begin
         wake_src = SRC_NONMASKABLE_INTERRUPT_PIN;
      // R8: falling edge, maskable
      end else if (irq_fall & r.wake_en[WAKE_IRQ_BIT]) begin
         wake_src = SRC_IRQ;
      end else if (|key_hit) begin
         wake_src = SRC_KEY;
      // R7: CAN port logic still sees bus activity
      end else if (can_activity & r.wake_en[WAKE_CAN_BIT]) begin
         wake_src = SRC_CAN;
      // R10: timer and watchdog clocked except in stop
      end else if (r.mode != MODE_STOP && timer_irq &&
                   r.wake_en[WAKE_TIMER_BIT]) begin
         wake_src = SRC_TIMER;
      end else if (r.mode != MODE_STOP && wdog_irq &&
                   r.wake_en[WAKE_WDOG_BIT]) begin
         wake_src = SRC_WDOG;
      // R12: any unmasked interrupt in wait
      end else if (r.mode == MODE_WAIT && periph_irq &&
                   r.wake_en[WAKE_PERIPH_BIT]) begin
         wake_src = SRC_PERIPH;
      end
   end

   assign wake_any = (wake_src != SRC_NONE);

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   function automatic logic [31:0] rd_word(input logic [31:0] a,
                                           input ctl_s s);
      logic [31:0] d;
      d = '0;
      case (a)
         ADDR_CLOCK_SEL: d[PSTOP_BIT] = s.pstop_sel;
         ADDR_WAKE_EN: d[WAKE_EN_W-1:0] = s.wake_en;
         ADDR_KEY_CFG: begin
            d[KEY_EN_LSB +: KEY_W] = s.key_en;
            d[KEY_EDGE_LSB +: KEY_W] = s.key_edge;
         end
         ADDR_PERIPH_EN: d[PERIPH_W-1:0] = s.periph_en;
         ADDR_MODE_STAT: begin
            d[STAT_MODE_LSB +: 2] = s.mode;
            d[STAT_STATE_LSB +: 3] = s.state;
            d[STAT_SRC_LSB +: 3] = s.src;
         end
         ADDR_IRQ_STAT: d[EV_W-1:0] = s.ev_stat;
         ADDR_IRQ_EN: d[EV_W-1:0] = s.ev_en;
         ADDR_RET_ADDR: d[PC_W-1:0] = s.ret_addr;
         default: d = '0;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      ev_set = '0;
      n.vector_fetch = 1'b0;
      n.resume_next = 1'b0;
      n.irq_prev = irq_n;
      n.nonmaskable_interrupt_pin_prev = nonmaskable_interrupt_pin_n;
      n.key_prev = key_pins;
      case (r.state)
         ST_RUN: begin
            // R3: only the two instructions leave run
            if (stop_take) begin
               n.state = ST_STACK;
               // R2: select bit read at execution
               n.mode = r.pstop_sel ? MODE_PSTOP : MODE_STOP;
               // R5: return to following instruction
               n.ret_addr = next_pc;
            // R1: stop-disable turns stop into a no-op
            end else if (stop_instr) begin
               ev_set[EV_STOP_REFUSED] = 1'b1;
            end else if (wait_take) begin
               n.state = ST_STACK;
               n.mode = MODE_WAIT;
               n.ret_addr = next_pc;
            end
         end
         ST_STACK: begin
            // R4: clocks stay on until stacking done
            if (stack_done) begin
               n.state = ST_GATED;
            end
         end
         ST_GATED: begin
            if (wake_any) begin
               n.src = wake_src;
               n.nonmaskable_interrupt_pin_masked = (wake_src == SRC_NONMASKABLE_INTERRUPT_PIN) & nonmaskable_interrupt_pin_mask;
               ev_set[EV_WAKE] = 1'b1;
               // R17: stop exit waits for oscillator
               if (r.mode == MODE_STOP) begin
                  n.state = ST_OSC_WAIT;
                  n.osc_cnt = OSC_LOAD;
               end else begin
                  n.state = ST_RESTORE;
               end
            end
         end
         ST_OSC_WAIT: begin
            if (r.osc_cnt == '0) begin
               n.state = ST_RESTORE;
               ev_set[EV_OSC_READY] = 1'b1;
            end else begin
               n.osc_cnt = r.osc_cnt - 1'b1;
            end
         end
         ST_RESTORE: begin
            // R18: one cycle with clocks on before resuming
            n.state = ST_RUN;
            n.mode = MODE_RUN;
            // R16: masked nonmaskable wake skips vector
            if (r.nonmaskable_interrupt_pin_masked) begin
               n.resume_next = 1'b1;
            // R15: vector fetch of waking source
            end else begin
               n.vector_fetch = 1'b1;
            end
         end
         default: begin
            n.state = ST_RUN;
            n.mode = MODE_RUN;
         end
      endcase
      // R13: configuration changes only by bus writes
      if (r.wr_pend) begin
         case (r.wr_addr)
            ADDR_CLOCK_SEL: n.pstop_sel = hwdata[PSTOP_BIT];
            ADDR_WAKE_EN: n.wake_en = hwdata[WAKE_EN_W-1:0];
            ADDR_KEY_CFG: begin
               n.key_en = hwdata[KEY_EN_LSB +: KEY_W];
               n.key_edge = hwdata[KEY_EDGE_LSB +: KEY_W];
            end
            ADDR_PERIPH_EN: n.periph_en = hwdata[PERIPH_W-1:0];
            ADDR_IRQ_EN: n.ev_en = hwdata[EV_W-1:0];
            default: n.ev_en = r.ev_en;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (r.wr_pend && r.wr_addr == ADDR_IRQ_CLR) begin
         n.ev_stat = (r.ev_stat & ~hwdata[EV_W-1:0]) | ev_set;
      end else begin
         n.ev_stat = r.ev_stat | ev_set;
      end
      // Zero-wait slave; read data fetched in the address phase
      n.wr_pend = hsel & hready & htrans[1] & hwrite;
      n.wr_addr = haddr;
      if (hsel && hready && htrans[1] && !hwrite) begin
         n.rdata = rd_word(haddr, r);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= CTL_RST;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign stack_req = (r.state == ST_STACK);
   assign return_addr = r.ret_addr;
   assign vector_fetch = r.vector_fetch;
   assign resume_next = r.resume_next;
   assign wake_source = r.src;
   assign irq = |(r.ev_stat & r.ev_en);

   // R6: oscillator off only while gated in stop
   assign osc_en = ~(gated & (r.mode == MODE_STOP));
   // R11: CPU halted whenever gated or restarting
   assign cpu_clk_en = (r.state == ST_RUN) | (r.state == ST_STACK) |
                       (r.state == ST_RESTORE);
   assign cpu_halt = ~cpu_clk_en;
   // R10: bus clock withheld in both stop modes
   assign bus_clk_en = cpu_clk_en | (gated & (r.mode == MODE_WAIT));
   assign timer_clk_en = cpu_clk_en | (gated & (r.mode != MODE_STOP));
   // R12: CAN stays clocked in wait for first message
   assign can_clk_en = bus_clk_en;
   // R11: only enabled modules clocked in wait
   assign periph_clk_en = cpu_clk_en ? {PERIPH_W{1'b1}} :
      ((gated && r.mode == MODE_WAIT) ? r.periph_en : '0);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_stop_refused: assert property ( // R1
      r.state == ST_RUN && stop_instr && stop_disable
      |=> r.state == ST_RUN && r.ev_stat[EV_STOP_REFUSED])
      else $error("stop taken while disabled");
   a_pstop_select: assert property ( // R2
      stop_take |=> r.mode == ($past(r.pstop_sel) ? MODE_PSTOP : MODE_STOP))
      else $error("wrong stop mode selected");
   a_run_stays: assert property ( // R3
      r.state == ST_RUN && !stop_instr && !wait_instr |=> r.state == ST_RUN)
      else $error("left run without instruction");
   a_stack_first: assert property ( // R4
      r.state == ST_STACK && !stack_done |=> r.state == ST_STACK && cpu_clk_en)
      else $error("clocks gated before stacking");
   a_return_addr: assert property ( // R5
      stop_take || wait_take |=> return_addr == $past(next_pc))
      else $error("wrong return address");
   a_stop_no_timer: assert property ( // R7
      gated && r.mode == MODE_STOP && !nonmaskable_interrupt_pin_fall && !irq_fall &&
      key_hit == '0 && !can_activity |=> r.state == ST_GATED && !osc_en)
      else $error("internal source woke stop mode");
   a_irq_edge: assert property ( // R8
      gated && irq_fall && r.wake_en[WAKE_IRQ_BIT] && !nonmaskable_interrupt_pin_fall
      |=> r.src == SRC_IRQ && r.state != ST_GATED)
      else $error("interrupt pin edge missed");
   a_pstop_clocks: assert property ( // R10
      gated && r.mode == MODE_PSTOP
      |-> osc_en && timer_clk_en && !bus_clk_en && periph_clk_en == '0)
      else $error("pseudo-stop clocking wrong");
   a_wait_wake: assert property ( // R12
      gated && r.mode == MODE_WAIT && periph_irq && r.wake_en[WAKE_PERIPH_BIT]
      |=> r.state == ST_RESTORE ##1 (vector_fetch ^ resume_next))
      else $error("wait not woken by interrupt");
   a_config_kept: assert property ( // R13
      gated && !r.wr_pend |=> $stable(r.wake_en) && $stable(r.periph_en))
      else $error("configuration changed while gated");
   a_nonmaskable_interrupt_pin_masked: assert property ( // R16
      r.state == ST_RESTORE && r.nonmaskable_interrupt_pin_masked |=> resume_next && !vector_fetch)
      else $error("vector fetched on masked wake");
   a_osc_delay: assert property ( // R17
      gated && r.mode == MODE_STOP && wake_any
      |=> r.state == ST_OSC_WAIT && r.osc_cnt == OSC_LOAD && !cpu_clk_en)
      else $error("stop exit skipped oscillator delay");
   a_clocks_first: assert property ( // R18
      vector_fetch || resume_next
      |-> $past(r.state == ST_RESTORE) && $past(cpu_clk_en) && osc_en)
      else $error("resumed before clocks restored");

endmodule // lpm_ctrl

// ==== cpu_core_model.sv ====
// Behavioural CPU core that answers the stacking request
module cpu_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic stack_req,
   input wire logic [3:0] stack_delay,
   output logic stack_done
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] cnt_r;

   // -----------------------------------------------------------------
   // Stacking handshake
   // -----------------------------------------------------------------
   // stacking before gating
   // Delay set per scenario so both prompt and slow answers are seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 4'h0;
         stack_done <= 1'b0;
      end else if (stack_done) begin
         cnt_r <= 4'h0;
         stack_done <= 1'b0;
      end else if (stack_req) begin
         if (cnt_r == stack_delay) begin
            stack_done <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule // cpu_core_model

// ==== mcu_low_power_mode_control_bench.sv ====
// Self-checking bench of the low-power mode controller
module mcu_low_power_mode_control_bench
   import lpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam int OSC = 4;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic stop_instr = 1'b0, wait_instr = 1'b0, stop_disable = 1'b0;
   logic nonmaskable_interrupt_pin_mask = 1'b0, irq_n = 1'b1;
   logic nonmaskable_interrupt_pin_n = 1'b1, can_activity = 1'b0;
   logic timer_irq = 1'b0, wdog_irq = 1'b0, periph_irq = 1'b0;
   logic [15:0] next_pc = 16'h0, return_addr;
   logic [7:0] key_pins = 8'h00, periph_clk_en;
   logic [3:0] stack_delay = 4'h3;
   logic stack_done, stack_req, cpu_halt, vector_fetch, resume_next;
   logic osc_en, cpu_clk_en, bus_clk_en, timer_clk_en, can_clk_en;
   logic irq, hreadyout, hresp;
   logic [2:0] wake_source;
   int num_errors = 0, n_compared = 0;

   lpm_ctrl #(.OSC_RESTART_CYC(OSC)) dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .stop_instr, .wait_instr, .stop_disable,
      .nonmaskable_interrupt_pin_mask, .next_pc, .stack_done, .stack_req, .cpu_halt, .return_addr,
      .vector_fetch, .resume_next, .wake_source, .irq_n,
      .nonmaskable_interrupt_pin_n, .key_pins, .can_activity, .timer_irq,
      .wdog_irq, .periph_irq, .osc_en, .cpu_clk_en, .bus_clk_en,
      .timer_clk_en, .can_clk_en, .periph_clk_en, .irq);

   cpu_core_model cpu (.hclk, .hresetn, .stack_req, .stack_delay,
      .stack_done);

   initial begin
      forever #2.5 hclk = ~hclk;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic report_and_stop();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // Issue one instruction and wait until the clocks are gated
   task automatic lp(input logic stp, input logic [15:0] pc);
      int n;
      @(posedge hclk);
      stop_instr <= stp;
      wait_instr <= !stp;
      next_pc <= pc;
      @(posedge hclk);
      stop_instr <= 1'b0;
      wait_instr <= 1'b0;
      #1;
      chk(32'({stack_req, cpu_clk_en}), 32'h3);
      n = 0;
      while (cpu_halt !== 1'b1 && n < 50) begin
         @(posedge hclk);
         #1;
         n++;
      end
      chk(32'({cpu_halt, return_addr}), 32'({1'b1, pc}));
   endtask

   // Wake input was driven at the edge just before the call
   task automatic wk(input int lat, input logic [1:0] pls,
                     input logic [2:0] src);
      repeat (lat) @(posedge hclk);
      #1;
      chk(32'({vector_fetch, resume_next, cpu_halt, wake_source}),
          32'({pls, 1'b0, src}));
      @(posedge hclk);
      #1;
      chk(32'({vector_fetch, resume_next}), 32'h0);
   endtask

   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(ADDR_CLOCK_SEL, 32'h0);
      rdc(ADDR_WAKE_EN, 32'h0);
      rdc(ADDR_KEY_CFG, 32'h0);
      rdc(ADDR_PERIPH_EN, 32'hff);
      rdc(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_RET_ADDR, 32'hffff);
      rdc(ADDR_RET_ADDR, 32'h0);
      rdc(32'h40, 32'h0);
      chk(32'({cpu_halt, cpu_clk_en, bus_clk_en}), 32'h3);
      chk(32'({hreadyout, hresp}), 32'h2);
      // Refused stop raises a status event
      stop_disable <= 1'b1;
      @(posedge hclk);
      stop_instr <= 1'b1;
      @(posedge hclk);
      stop_instr <= 1'b0;
      repeat (3) @(posedge hclk);
      #1;
      chk(32'({stack_req, cpu_halt}), 32'h0);
      rdc(ADDR_IRQ_STAT, 32'h2);
      wr(ADDR_IRQ_EN, 32'h2);
      rdc(ADDR_IRQ_EN, 32'h2);
      chk(32'(irq), 32'h1);
      wr(ADDR_IRQ_CLR, 32'h2);
      rdc(ADDR_IRQ_STAT, 32'h0);
      chk(32'(irq), 32'h0);
      stop_disable <= 1'b0;
      // Wait mode, peripheral wake
      wr(ADDR_WAKE_EN, 32'h10);
      wr(ADDR_PERIPH_EN, 32'h0f);
      lp(1'b0, 16'h1234);
      chk(32'({osc_en, cpu_clk_en, timer_clk_en, can_clk_en,
               periph_clk_en}), 32'h0b0f);
      @(posedge hclk);
      periph_irq <= 1'b1;
      wk(2, 2'b10, SRC_PERIPH);
      periph_irq <= 1'b0;
      rdc(ADDR_RET_ADDR, 32'h1234);
      rdc(ADDR_PERIPH_EN, 32'h0f);
      // Stop: timer and watchdog cannot wake, interrupt pin can
      wr(ADDR_WAKE_EN, 32'h0d);
      lp(1'b1, 16'h2000);
      chk(32'({osc_en, cpu_clk_en, bus_clk_en, timer_clk_en}), 32'h0);
      @(posedge hclk);
      timer_irq <= 1'b1;
      wdog_irq <= 1'b1;
      repeat (5) @(posedge hclk);
      #1;
      chk(32'(cpu_halt), 32'h1);
      @(posedge hclk);
      irq_n <= 1'b0;
      wk(OSC + 2, 2'b10, SRC_IRQ);
      irq_n <= 1'b1;
      timer_irq <= 1'b0;
      wdog_irq <= 1'b0;
      // Stop: bus activity wakes
      wr(ADDR_WAKE_EN, 32'h02);
      lp(1'b1, 16'h2100);
      @(posedge hclk);
      can_activity <= 1'b1;
      wk(OSC + 2, 2'b10, SRC_CAN);
      can_activity <= 1'b0;
      // Pseudo-stop: timer keeps running and wakes without restart delay
      wr(ADDR_CLOCK_SEL, 32'h1);
      wr(ADDR_WAKE_EN, 32'h04);
      lp(1'b1, 16'h3000);
      chk(32'({osc_en, cpu_clk_en, bus_clk_en, timer_clk_en,
               can_clk_en}), 32'h12);
      rdc(ADDR_MODE_STAT, 32'h433);
      @(posedge hclk);
      timer_irq <= 1'b1;
      wk(2, 2'b10, SRC_TIMER);
      timer_irq <= 1'b0;
      // Pseudo-stop: watchdog also wakes
      wr(ADDR_WAKE_EN, 32'h08);
      lp(1'b1, 16'h3100);
      @(posedge hclk);
      wdog_irq <= 1'b1;
      wk(2, 2'b10, SRC_WDOG);
      wdog_irq <= 1'b0;
      // Wait: key rising edge, prompt stacking answer
      wr(ADDR_CLOCK_SEL, 32'h0);
      wr(ADDR_WAKE_EN, 32'h0);
      wr(ADDR_KEY_CFG, 32'h0101);
      stack_delay <= 4'h0;
      lp(1'b0, 16'h4000);
      @(posedge hclk);
      key_pins <= 8'h01;
      wk(2, 2'b10, SRC_KEY);
      key_pins <= 8'h00;
      // Nonmaskable pin, masked in wait then unmasked in stop
      for (int i = 0; i < 2; i++) begin
         nonmaskable_interrupt_pin_mask <= (i == 0);
         lp(i == 1, 16'h5000);
         @(posedge hclk);
         nonmaskable_interrupt_pin_n <= 1'b0;
         wk(i == 0 ? 2 : OSC + 2, i == 0 ? 2'b01 : 2'b10, SRC_NONMASKABLE_INTERRUPT_PIN);
         nonmaskable_interrupt_pin_n <= 1'b1;
      end
      report_and_stop();
   end
endmodule // mcu_low_power_mode_control_bench
